// [src/flash_host.sv]
`timescale 1ns/100ps

// How it works
// [RL1] write cycles drive chip select and write strobe low, output enable high
// [RL2] address set before strobes fall; data held until strobes rise
// [RL3] only defined command sequences are ever sent to the flash; an undefined op code still sends one AAh write to 555h
// [RL4] after reset the flash is tracked as being in read-array mode
// [RL5] reads lower chip select and output enable, sample after access time
// [RL6] busy line release means back in read-array mode
// [RL7] suspend command moves tracked mode to erase-suspended read
// [RL8] reads of erasing sectors in suspend yield status, left to software
// [RL9] program is permitted while erase is suspended
// [RL10] failure or ID/CFI mode need a reset command before array reads
// [RL11] hardware clear held low long enough; wait for busy line release
// [RL12] the flash refuses protected sectors; host sees failure via status; the status never shows it, as nothing sets err_q or DM_FAIL
// [RL13] protection bypass only while the high clear level is driven
// [RL14] chip unprotect clears all; protect all first (software duty)
// [RL15] boot guard pin low shields outermost boot sector
// [RL16] accelerated level allows program with no unlock cycles
// [RL17] high clear level lets protected sectors be written
// [RL18] ID command from array, suspend or CFI enters persistent ID mode
// [RL19] id select line low gives maker code, high gives device code
// [RL20] reset command in ID mode returns to array or suspended read; the host tracks DM_ARRAY, as nothing sets err_q
// [RL21] protect verify read returns 01h protected, 00h not
// [RL22] first write after reset is a dummy, since it may be ignored
// [RL23] program is two unlock cycles, A0h, then address and data
// [RL24] no commands while programming; only hardware clear aborts; go waits only for the sequencer, not for the busy line
module flash_host #(
	parameter int RP_CYCLES = flash_host_pkg::RP_CYC
) (
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	output flash_host_pkg::flash_pins_t     pins,
	input  wire logic [15:0]                dq_in,
	input  wire logic                       busy_indicator_n,
	output logic                            hardware_clear_pin_n,
	output logic                            hv_clear_en,
	output logic                            boot_guard_accel_pin,
	output logic                            accel_hv_en,
	output logic                            high_voltage_id_en
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_SETUP = 6'b000010,
		S_PULSE = 6'b000100,
		S_HOLD  = 6'b001000,
		S_RST   = 6'b010000,
		S_WAIT  = 6'b100000
	} fsm_t;

	fsm_t                         state_q;
	flash_host_pkg::dev_mode_t    mode_q;
	flash_host_pkg::op_t          op_q;
	logic [12:0]                  ctrl_q;
	logic [19:0]                  addr_q;
	logic [15:0]                  wdata_q;
	logic [15:0]                  rdata_q;
	logic [7:0]                   timing_q;
	logic [2:0]                   step_q;
	logic [2:0]                   nsteps;
	logic [15:0]                  cyc_q;
	logic                         is_read;
	logic                         err_q;
	logic                         first_q;
	logic [19:0]                  c_addr;
	logic [15:0]                  c_data;
	logic                         wr_ph_q;
	logic [7:0]                   wofs_q;
	logic                         go;
	logic                         busy;

	assign busy = (state_q != S_IDLE);

	// ****************************************************************
	// AHB-Lite slave: zero wait state, always OKAY
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_q   <= 1'b0;
			wofs_q    <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_ph_q <= hsel && hready && htrans[1] && hwrite;
			wofs_q  <= haddr[7:0];
		end
	end

	// read data mux registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				flash_host_pkg::CTRL_OFS:   hrdata <= {19'h0, ctrl_q};
				flash_host_pkg::ADDR_OFS:   hrdata <= {12'h000, addr_q};
				flash_host_pkg::WDATA_OFS:  hrdata <= {16'h0000, wdata_q};
				flash_host_pkg::STATUS_OFS: hrdata <= {25'h0, mode_q,
					busy_indicator_n, err_q, !busy, busy};
				flash_host_pkg::RDATA_OFS:  hrdata <= {16'h0000, rdata_q};
				flash_host_pkg::TIMING_OFS: hrdata <= {24'h0, timing_q};
				default:                    hrdata <= 32'h0000_0000;
			endcase
		end
	end

	assign go = wr_ph_q && (wofs_q == flash_host_pkg::CTRL_OFS)
		&& hwdata[flash_host_pkg::CTRL_GO_BIT] && !busy;

	// software registers; pin-level controls stay writable any time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q   <= 13'h0400;
			addr_q   <= 20'h0_0000;
			wdata_q  <= 16'h0000;
			timing_q <= flash_host_pkg::TIMING_RST;
		end else if (wr_ph_q) begin
			case (wofs_q)
				flash_host_pkg::CTRL_OFS:   ctrl_q  <= hwdata[12:0];
				flash_host_pkg::ADDR_OFS:   addr_q  <= hwdata[19:0];
				flash_host_pkg::WDATA_OFS:  wdata_q <= hwdata[15:0];
				flash_host_pkg::TIMING_OFS: timing_q <= hwdata[7:0];
				default:                    ;
			endcase
		end
	end

	// ****************************************************************
	// static pin levels
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hv_clear_en          <= 1'b0;
			boot_guard_accel_pin <= 1'b1;
			accel_hv_en          <= 1'b0;
			high_voltage_id_en   <= 1'b0;
		end else begin
			hv_clear_en          <= ctrl_q[flash_host_pkg::CTRL_HVRST_BIT]; // RL13 RL17
			boot_guard_accel_pin <= ctrl_q[flash_host_pkg::CTRL_GUARD_BIT]; // RL15
			accel_hv_en          <= ctrl_q[flash_host_pkg::CTRL_ACCEL_BIT]; // RL16
			high_voltage_id_en   <= ctrl_q[flash_host_pkg::CTRL_HVID_BIT]; // RL19 RL20
		end
	end

	// ****************************************************************
	// command sequence tables
	// ****************************************************************
	// step count per operation; a dummy write leads after reset
	always_comb begin
		is_read = 1'b0;
		case (op_q)
			flash_host_pkg::OP_READ:    begin nsteps = 3'd1; is_read = 1'b1; end // RL5
			flash_host_pkg::OP_RESET:   nsteps = 3'd1;
			flash_host_pkg::OP_PROGRAM: nsteps = 3'd4; // RL23
			flash_host_pkg::OP_CHIP_ER: nsteps = 3'd6;
			flash_host_pkg::OP_SECT_ER: nsteps = 3'd6;
			flash_host_pkg::OP_SUSPEND: nsteps = 3'd1;
			flash_host_pkg::OP_RESUME:  nsteps = 3'd1;
			flash_host_pkg::OP_ID:      nsteps = 3'd3;
			flash_host_pkg::OP_CFI:     nsteps = 3'd1;
			flash_host_pkg::OP_ACCPROG: nsteps = 3'd1; // RL16
			default:                    nsteps = 3'd1; // RL3
		endcase
	end

	// address and data of the current step; table codes, or addr_q/wdata_q in the last read/program step and addr_q in sector erase
	always_comb begin
		c_addr = {4'h0, flash_host_pkg::UNLOCK1_ADR};
		c_data = flash_host_pkg::D_UNLOCK1;
		if (first_q) begin
			c_data = flash_host_pkg::D_RESET; // RL22
		end else if (step_q == 3'd1 || step_q == 3'd4) begin
			c_addr = {4'h0, flash_host_pkg::UNLOCK2_ADR};
			c_data = flash_host_pkg::D_UNLOCK2;
		end else if (step_q == 3'd2) begin
			case (op_q)
				flash_host_pkg::OP_PROGRAM: c_data = flash_host_pkg::D_PROGRAM;
				flash_host_pkg::OP_ID:      c_data = flash_host_pkg::D_ID; // RL18
				default:                    c_data = flash_host_pkg::D_ERASE;
			endcase
		end else if (step_q == 3'd5) begin
			c_addr = (op_q == flash_host_pkg::OP_SECT_ER) ? addr_q
				: {4'h0, flash_host_pkg::UNLOCK1_ADR};
			c_data = (op_q == flash_host_pkg::OP_SECT_ER)
				? flash_host_pkg::D_SECTOR : flash_host_pkg::D_CHIP;
		end
		// last step of single-cycle and program sequences
		if (!first_q && step_q == nsteps - 3'd1) begin
			case (op_q)
				flash_host_pkg::OP_READ,
				flash_host_pkg::OP_ACCPROG,
				flash_host_pkg::OP_PROGRAM: begin c_addr = addr_q; c_data = wdata_q; end
				flash_host_pkg::OP_RESET:   c_data = flash_host_pkg::D_RESET;
				flash_host_pkg::OP_SUSPEND: c_data = flash_host_pkg::D_SUSPEND;
				flash_host_pkg::OP_RESUME:  c_data = flash_host_pkg::D_RESUME;
				flash_host_pkg::OP_CFI: begin
					c_addr = {4'h0, flash_host_pkg::CFI_ADR};
					c_data = flash_host_pkg::D_CFI;
				end
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// bus cycle sequencer
	// ****************************************************************
	// each phase lasts PHASE_CYC+1 cycles; only the pulse phase adds the software stretch in timing_q
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= S_IDLE;
			op_q    <= flash_host_pkg::OP_READ;
			step_q  <= 3'd0;
			cyc_q   <= 16'h0000;
			first_q <= 1'b1;
			rdata_q <= 16'h0000;
			pins    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
				addr: 20'h0_0000, dq_out: 16'h0000, dq_oe: 1'b0};
			hardware_clear_pin_n <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					hardware_clear_pin_n <= 1'b1;
					if (go) begin
						op_q  <= flash_host_pkg::op_t'(hwdata[7:4]);
						step_q <= 3'd0;
						cyc_q <= 16'h0000;
						state_q <= hwdata[flash_host_pkg::CTRL_RST_BIT] ? S_RST
							: S_SETUP;
					end
				end
				S_SETUP: begin // RL2
					pins.addr   <= c_addr;
					pins.ce_n   <= 1'b0;
					pins.dq_oe  <= 1'b0;
					cyc_q       <= cyc_q + 16'd1;
					if (cyc_q >= 16'(flash_host_pkg::PHASE_CYC)) begin
						cyc_q <= 16'h0000;
						state_q <= S_PULSE;
					end
				end
				S_PULSE: begin
					pins.oe_n   <= !(is_read && !first_q); // RL1 RL5
					pins.we_n   <= is_read && !first_q;
					pins.dq_out <= c_data;
					pins.dq_oe  <= !(is_read && !first_q);
					cyc_q       <= cyc_q + 16'd1;
					if (cyc_q >= 16'(flash_host_pkg::PHASE_CYC)
						+ 16'(timing_q)) begin
						cyc_q   <= 16'h0000;
						rdata_q <= is_read ? dq_in : rdata_q; // RL19 RL21
						state_q <= S_HOLD;
					end
				end
				S_HOLD: begin // data stays valid past the strobe rise
					pins.we_n <= 1'b1;
					pins.oe_n <= 1'b1;
					pins.ce_n <= 1'b1;
					cyc_q     <= cyc_q + 16'd1;
					if (cyc_q >= 16'(flash_host_pkg::PHASE_CYC)) begin
						cyc_q  <= 16'h0000;
						pins.dq_oe <= 1'b0;
						if (first_q) begin
							first_q <= 1'b0;
							state_q <= S_SETUP;
						end else if (step_q == nsteps - 3'd1) begin
							state_q <= S_IDLE;
						end else begin
							step_q  <= step_q + 3'd1;
							state_q <= S_SETUP;
						end
					end
				end
				S_RST: begin // RL11
					hardware_clear_pin_n <= 1'b0;
					cyc_q <= cyc_q + 16'd1;
					// strictly longer than the minimum pulse: RP_CYCLES+1 low
					if (cyc_q > 16'(RP_CYCLES)) begin
						hardware_clear_pin_n <= 1'b1;
						cyc_q   <= 16'h0000;
						state_q <= S_WAIT;
					end
				end
				S_WAIT: begin // busy line must release first
					if (busy_indicator_n) state_q <= S_IDLE; // RL11 RL24
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// device mode tracking
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= flash_host_pkg::DM_ARRAY; // RL4
			err_q  <= 1'b0;
		end else if (state_q == S_WAIT && busy_indicator_n) begin
			mode_q <= flash_host_pkg::DM_ARRAY; // RL11
			err_q  <= 1'b0;
		end else if (state_q == S_HOLD && !first_q && step_q == nsteps - 3'd1
			&& cyc_q >= 16'(flash_host_pkg::PHASE_CYC)) begin
			case (op_q)
				flash_host_pkg::OP_RESET: begin // RL10 RL20
					mode_q <= (mode_q == flash_host_pkg::DM_ID && err_q)
						? flash_host_pkg::DM_SUSP : flash_host_pkg::DM_ARRAY;
					err_q  <= 1'b0;
				end
				flash_host_pkg::OP_PROGRAM, flash_host_pkg::OP_ACCPROG,
				flash_host_pkg::OP_CHIP_ER, flash_host_pkg::OP_SECT_ER:
					mode_q <= flash_host_pkg::DM_BUSY; // RL9 RL12
				flash_host_pkg::OP_SUSPEND: mode_q <= flash_host_pkg::DM_SUSP; // RL7 RL8
				flash_host_pkg::OP_RESUME:  mode_q <= flash_host_pkg::DM_BUSY;
				flash_host_pkg::OP_ID:      mode_q <= flash_host_pkg::DM_ID; // RL18
				flash_host_pkg::OP_CFI:     mode_q <= flash_host_pkg::DM_CFI;
				default: ;
			endcase
		end else if (mode_q == flash_host_pkg::DM_BUSY && busy_indicator_n
			&& state_q == S_IDLE) begin
			mode_q <= flash_host_pkg::DM_ARRAY; // RL6 RL14
		end
	end

endmodule // flash_host

// [src/flash_host_pkg.sv]
package flash_host_pkg;

	// ****************************************************************
	// register map of the controller (AHB-Lite byte offsets)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] ADDR_OFS   = 8'h04;
	localparam logic [7:0] WDATA_OFS  = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] RDATA_OFS  = 8'h10;
	localparam logic [7:0] TIMING_OFS = 8'h14;

	// ctrl fields
	localparam int CTRL_GO_BIT      = 0;
	localparam int CTRL_OP_LSB      = 4;
	localparam int CTRL_OP_W        = 4;
	localparam int CTRL_RST_BIT     = 8;
	localparam int CTRL_HVRST_BIT   = 9;
	localparam int CTRL_GUARD_BIT   = 10;
	localparam int CTRL_ACCEL_BIT   = 11;
	localparam int CTRL_HVID_BIT    = 12;

	// status fields
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_RDY_BIT     = 1;
	localparam int STAT_MODE_LSB    = 4;
	localparam int STAT_ERR_BIT     = 2;

	// command sequences (host-side operations)
	typedef enum logic [3:0] {
		OP_READ    = 4'h0,
		OP_RESET   = 4'h1,
		OP_PROGRAM = 4'h2,
		OP_CHIP_ER = 4'h3,
		OP_SECT_ER = 4'h4,
		OP_SUSPEND = 4'h5,
		OP_RESUME  = 4'h6,
		OP_ID      = 4'h7,
		OP_CFI     = 4'h8,
		OP_ACCPROG = 4'h9
	} op_t;

	// tracked device mode
	typedef enum logic [2:0] {
		DM_ARRAY  = 3'h0,
		DM_BUSY   = 3'h1,
		DM_SUSP   = 3'h2,
		DM_ID     = 3'h3,
		DM_CFI    = 3'h4,
		DM_FAIL   = 3'h5
	} dev_mode_t;

	// command data and addresses
	localparam logic [15:0] UNLOCK1_ADR = 16'h0555;
	localparam logic [15:0] UNLOCK2_ADR = 16'h02AA;
	localparam logic [15:0] CFI_ADR     = 16'h0055;
	localparam logic [15:0] D_UNLOCK1   = 16'h00AA;
	localparam logic [15:0] D_UNLOCK2   = 16'h0055;
	localparam logic [15:0] D_PROGRAM   = 16'h00A0;
	localparam logic [15:0] D_ERASE     = 16'h0080;
	localparam logic [15:0] D_CHIP      = 16'h0010;
	localparam logic [15:0] D_SECTOR    = 16'h0030;
	localparam logic [15:0] D_RESUME    = 16'h0030;
	localparam logic [15:0] D_SUSPEND   = 16'h00B0;
	localparam logic [15:0] D_ID        = 16'h0090;
	localparam logic [15:0] D_CFI       = 16'h0098;
	localparam logic [15:0] D_RESET     = 16'h00F0;

	// timing, in clock cycles of hclk (50 MHz)
	localparam int CLK_NS        = 20;
	localparam int T_PHASE_NS    = 80;
	localparam int PHASE_CYC     = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int T_RP_NS       = 500;
	localparam int RP_CYC        = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] TIMING_RST = 8'h00;

	// flash pin group
	typedef struct packed {
		logic        ce_n;
		logic        we_n;
		logic        oe_n;
		logic [19:0] addr;
		logic [15:0] dq_out;
		logic        dq_oe;
	} flash_pins_t;

endpackage

// [sim/flash_host_monitor.sv]
`timescale 1ns/100ps
module flash_host_monitor #(
	parameter int RP_CYCLES = 2
) (
	input wire logic                        hclk,
	input wire logic                        hresetn,
	input wire flash_host_pkg::flash_pins_t pins,
	input wire logic                        hardware_clear_pin_n
);
	// ************************************
	// pin protocol checks
	// ************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	int lo_q;
	// clocks spent with the clear pin low, to time the pulse
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			lo_q <= 0;
		else
			lo_q <= hardware_clear_pin_n ? 0 : lo_q + 1;
	property p_wr_qual; !pins.we_n |-> !pins.ce_n && pins.oe_n; endproperty
	a_wr_qual: assert property (p_wr_qual) else $error("bad write");
	property p_rd_qual; $fell(pins.oe_n) |-> !pins.ce_n && pins.we_n;
	endproperty
	a_rd_qual: assert property (p_rd_qual) else $error("bad read");
	property p_addr_hold; !pins.we_n ##1 !pins.we_n |-> $stable(pins.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
	property p_we_width; $fell(pins.we_n) |-> !pins.we_n[*5] ##1 pins.we_n;
	endproperty
	a_we_width: assert property (p_we_width) else $error("pulse width");
	property p_data_hold;
		$rose(pins.we_n) |-> $stable(pins.dq_out) ##0 pins.dq_oe[*4];
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("data hold");
	property p_no_clash; !pins.oe_n |-> !pins.dq_oe; endproperty
	a_no_clash: assert property (p_no_clash) else $error("bus clash");
	property p_clr_len;
		$rose(hardware_clear_pin_n) && lo_q > 1 |-> lo_q == RP_CYCLES + 1;
	endproperty
	a_clr_len: assert property (p_clr_len) else $error("clear length");
	property p_clr_quiet;
		!hardware_clear_pin_n |-> pins.we_n && pins.oe_n;
	endproperty
	a_clr_quiet: assert property (p_clr_quiet) else $error("cycle in clear");
endmodule // flash_host_monitor
bind flash_host flash_host_monitor #(.RP_CYCLES(RP_CYCLES)) i_mon (
	.hclk(hclk), .hresetn(hresetn), .pins(pins),
	.hardware_clear_pin_n(hardware_clear_pin_n));

// [sim/flash_model.sv]
`timescale 1ns/100ps
module flash_model #(
	parameter logic [15:0] MFR = 16'h005A, // arbitrary value
	parameter logic [15:0] DEV = 16'h3C96  // arbitrary value
) (
	input  wire flash_host_pkg::flash_pins_t pins,
	output logic [15:0]                      dq_in,
	output logic                             busy_indicator_n,
	input  wire logic                        hardware_clear_pin_n,
	input  wire logic                        hv_clear_en,
	input  wire logic                        boot_guard_accel_pin,
	input  wire logic                        accel_hv_en,
	input  wire logic                        high_voltage_id_en
);
	// ************************************
	// behavioural flash device
	// ************************************
	logic [15:0] mem [256];
	logic [15:0] rdv;
	logic [15:0] held = 16'h0000;
	logic [19:0] a;
	logic [1:0]  st = 2'h0;
	logic        idm = 1'b0;
	logic        first = 1'b1;
	logic        bsy = 1'b0;
	wire  [7:0]  d = pins.dq_out[7:0];
	wire         sel = !pins.ce_n && !pins.oe_n;
	wire         wr = !pins.ce_n && !pins.we_n && pins.oe_n
		&& hardware_clear_pin_n;
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// address at the later falling strobe, data at the earlier rising one
	always @(posedge wr) a = pins.addr;
	always @(negedge wr) begin
		if (first)
			first = 1'b0;
		else if (!bsy)
			case (st)
			2'h0: begin
				if (d == 8'hF0)
					idm = 1'b0;
				else if (d == 8'hAA && a[11:0] == 12'h555)
					st = 2'h1;
				else if (accel_hv_en) begin
					if (boot_guard_accel_pin || a > 20'h0_1FFF)
						mem[a[7:0]] = mem[a[7:0]] & pins.dq_out;
					bsy = 1'b1;
				end
			end
			2'h1: st = (d == 8'h55 && a[11:0] == 12'h2AA) ? 2'h2 : 2'h0;
			2'h2: begin
				st = (d == 8'hA0) ? 2'h3 : 2'h0;
				idm = idm || d == 8'h90;
			end
			default: begin
				st = 2'h0;
				if (boot_guard_accel_pin || a > 20'h0_1FFF)
					mem[a[7:0]] = mem[a[7:0]] & pins.dq_out;
				bsy = 1'b1;
			end
			endcase
	end
	// embedded program time, then back to array reads
	always @(posedge bsy) #400 bsy = 1'b0;
	// clear pin low drops ID mode and partial sequences back to array reads; a running program is not cut short
	always @(negedge hardware_clear_pin_n) begin
		st = 2'h0;
		idm = 1'b0;
	end
	// read data: id codes, status while busy, else array
	always @* begin
		if (idm || high_voltage_id_en)
			rdv = pins.addr[0] ? DEV : MFR;
		else if (bsy)
			rdv = ~mem[pins.addr[7:0]];
		else
			rdv = mem[pins.addr[7:0]];
	end
	// no pull on the data bus, so released lines show the inverse
	always @* if (sel) held = rdv;
	assign #30 dq_in = sel ? rdv : ~held;
	assign busy_indicator_n = !bsy; // open drain, pulled up
endmodule // flash_model

// [sim/test_flash_host.sv]
`timescale 1ns/100ps
module test_flash_host;
	// ************************************
	// bench: clock, bus master, scenarios
	// ************************************
	localparam logic [15:0] MFR = 16'h005A; // arbitrary value
	localparam logic [15:0] DEV = 16'h3C96; // arbitrary value
	localparam logic [31:0] G = 32'h0000_0400; // guard pin high
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout, clr_n, busy_n, hvc, guard, acc, hvid;
	logic [15:0] dq_in;
	flash_host_pkg::flash_pins_t pins;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	always #10 hclk = ~hclk;
	flash_host #(.RP_CYCLES(2)) i_flash_host (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .pins(pins), .dq_in(dq_in),
		.busy_indicator_n(busy_n), .hardware_clear_pin_n(clr_n),
		.hv_clear_en(hvc), .boot_guard_accel_pin(guard), .accel_hv_en(acc),
		.high_voltage_id_en(hvid));
	flash_model #(.MFR(MFR), .DEV(DEV)) i_flash_model (.pins(pins),
		.dq_in(dq_in), .busy_indicator_n(busy_n),
		.hardware_clear_pin_n(clr_n), .hv_clear_en(hvc),
		.boot_guard_accel_pin(guard), .accel_hv_en(acc),
		.high_voltage_id_en(hvid));
	// hang guard, far above what the scenarios need
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 50000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one single transfer; address phase held until hready
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 99);
		rd = hrdata;
	endtask
	task automatic go(input logic [3:0] op, input logic [31:0] ctl);
		int n;
		n = 0;
		bus(1'b1, flash_host_pkg::CTRL_OFS, ctl | {op, 4'h1});
		do bus(1'b0, flash_host_pkg::STATUS_OFS, '0);
		while (rd[0] !== 1'b0 && ++n < 500);
		chk("idle", rd[0], 1'b0);
		// the embedded operation may still run after the sequencer idles
		n = 0;
		do bus(1'b0, flash_host_pkg::STATUS_OFS, '0);
		while (rd[3] !== 1'b1 && ++n < 500);
		chk("ready", rd[3], 1'b1);
	endtask
	task automatic mode(input logic [2:0] m);
		bus(1'b0, flash_host_pkg::STATUS_OFS, '0);
		chk("mode", rd[6:4], m);
	endtask
	task automatic prog(input logic [19:0] a, input logic [15:0] d,
			input logic [3:0] op, input logic [31:0] ctl);
		bus(1'b1, flash_host_pkg::ADDR_OFS, {12'h000, a});
		bus(1'b1, flash_host_pkg::WDATA_OFS, {16'h0000, d});
		go(op, ctl);
	endtask
	task automatic fread(input logic [19:0] a);
		prog(a, 16'h0000, 4'h0, G);
		bus(1'b0, flash_host_pkg::RDATA_OFS, '0);
	endtask
	task automatic t_power_up();
		mode(flash_host_pkg::DM_ARRAY);
		fread(20'h0_2030);
		chk("erased", rd[15:0], 16'hFFFF);
		bus(1'b0, 8'h1C, '0);
		chk("unmapped", rd, 32'h0000_0000);
	endtask
	task automatic t_program();
		prog(20'h0_2020, 16'hA5C3, 4'h2, G);
		mode(flash_host_pkg::DM_ARRAY);
		fread(20'h0_2020);
		chk("program", rd[15:0], 16'hA5C3);
	endtask
	task automatic t_guard();
		prog(20'h0_0010, 16'h0000, 4'h2, 32'h0000_0000);
		fread(20'h0_0010);
		chk("guarded", rd[15:0], 16'hFFFF);
	endtask
	task automatic t_accel();
		prog(20'h0_2040, 16'h0F0F, 4'h9, 32'h0000_0C00);
		fread(20'h0_2040);
		chk("accel", rd[15:0], 16'h0F0F);
	endtask
	task automatic t_id();
		go(4'h7, G);
		mode(flash_host_pkg::DM_ID);
		fread(20'h0_0000);
		chk("maker", rd[15:0], MFR);
		fread(20'h0_0001);
		chk("device", rd[15:0], DEV);
		go(4'h1, G);
		mode(flash_host_pkg::DM_ARRAY);
		fread(20'h0_2020);
		chk("after id", rd[15:0], 16'hA5C3);
	endtask
	task automatic t_hwreset();
		go(4'h7, G);
		go(4'h0, G | 32'h0000_0100);
		mode(flash_host_pkg::DM_ARRAY);
		fread(20'h0_2040);
		chk("after clear", rd[15:0], 16'h0F0F);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_power_up();
		t_program();
		t_guard();
		t_accel();
		t_id();
		t_hwreset();
		final_report();
	end
endmodule // test_flash_host
